// ===== rtl/fir_coef_pkg.sv
// Constants for the channel A coefficient store of the 9-tap equalizer.
// Assumes a byte-wide register port with byte addresses.
// How it works
// - Side taps: 12-bit signed, bits 15:12 reserved
// - Nine taps; fifth is 18-bit center tap
// - Bank A feeds filter A or merged filter
// - tap0 to tap5 map to taps one-six
// - Offsets 0x418, 0x41A, 0x41C, 0x41E, 0x420, 0x423
// - All bits read/write, reset to zero
// - Side weight 0..6 scales side LSB only
// - Sharing bit makes B use A coefficients
// - Mode 0 bypass, 2 active, others reserved
package fir_coef_pkg;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned SIDE_W     = 12;
  localparam int unsigned CENTER_W   = 18;
  localparam int unsigned SIDE_REG_W = 16;
  localparam int unsigned CTR_REG_W  = 24;
  localparam int unsigned NUM_REGS   = 6;
  // Byte base of each register, index 0 is tap0
  localparam logic [11:0] CFG_OFF   = 12'h0400;
  localparam logic [11:0] TAP0_OFF  = 12'h0418;
  localparam logic [11:0] TAP1_OFF  = 12'h041a;
  localparam logic [11:0] TAP2_OFF  = 12'h041c;
  localparam logic [11:0] TAP3_OFF  = 12'h041e;
  localparam logic [11:0] TAP4C_OFF = 12'h0420;
  localparam logic [11:0] TAP5_OFF  = 12'h0423;
  localparam int unsigned CENTER_IDX = 4;
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [23:0] TAP_RESET  = 24'h00_0000;
  // Config byte fields
  localparam int unsigned MODE_LSB  = 0;
  localparam int unsigned SCW_LSB   = 2;
  localparam int unsigned MERGE_BIT = 5;
  localparam int unsigned SHARE_BIT = 6;
  localparam logic [2:0]  SCW_MAX   = 3'h6;
  typedef enum logic [1:0] {
    MODE_BYPASS = 2'h0,
    MODE_RSVD1  = 2'h1,
    MODE_ACTIVE = 2'h2,
    MODE_RSVD3  = 2'h3
  } filter_mode_t;
endpackage

// ===== rtl/coef_byte_reg.sv
`timescale 1ns/1ps
// One multi-byte coefficient register written and read a byte at a time.
// Assumes byte offset decoding by the caller.
module coef_byte_reg #(
  parameter int unsigned NBYTES = 2
) (
  input  wire logic                  clock_in,
  input  wire logic                  rst_in,
  input  wire logic                  wr_in,
  input  wire logic [1:0]            byte_sel_in,
  input  wire logic [7:0]            wdata_in,
  output logic      [NBYTES*8-1:0]   value_out
);
  typedef struct packed {
    logic [NBYTES*8-1:0] value;
  } state_t;
  state_t s_q;
  state_t s_d;

  always_comb
  begin
    s_d = s_q;
    if (wr_in)
    begin
      // Little-endian byte assembly
      s_d.value[byte_sel_in*8 +: 8] = wdata_in;
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      s_q <= '{value: '0};
    else
      s_q <= s_d;
  end

  assign value_out = s_q.value;
endmodule

// ===== rtl/fir_coefficient_bank_a.sv
`timescale 1ns/1ps
// Channel A coefficient store and filter configuration byte.
// Assumes a host port with one-cycle strobes, read data the next cycle.
module fir_coefficient_bank_a (
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  input  wire logic        serial_link_enable_in,
  output logic      [7:0]  rdata_out,
  output logic      [1:0]  filter_mode_out,
  output logic             filter_active_out,
  output logic             filter_merge_out,
  output logic             coefficient_sharing_out,
  output logic      [2:0]  side_coefficient_weight_out,
  output logic      [4:0]  side_lsb_exponent_out,
  output logic      [8*12-1:0] side_taps_a_out,
  output logic      [17:0] center_tap_a_out,
  output logic             taps_a_drive_b_out,
  output logic             config_write_ignored_out
);
  localparam int unsigned NR = fir_coef_pkg::NUM_REGS;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] rdata;
    logic       ignored;
  } state_t;
  state_t s_q;
  state_t s_d;

  localparam int unsigned SIDE_NB = fir_coef_pkg::SIDE_REG_W / 8;
  localparam int unsigned CTR_NB  = fir_coef_pkg::CTR_REG_W / 8;

  logic [NR-1:0]  hit;
  logic [1:0]     bsel [NR];
  logic [11:0]    rel  [NR];
  logic [23:0]    val  [NR];
  logic [15:0]    tap0_value;
  logic [15:0]    tap1_value;
  logic [15:0]    tap2_value;
  logic [15:0]    tap3_value;
  logic [23:0]    tap4_value;
  logic [15:0]    tap5_value;
  logic [7:0]     rd_byte;
  logic           wr_ok;

  // Edits with the link running are dropped to protect the stream
  assign wr_ok = wr_in && !serial_link_enable_in;

  // Window decode; each register answers for its own bytes only
  always_comb
  begin
    rel[0] = addr_in - fir_coef_pkg::TAP0_OFF;
    rel[1] = addr_in - fir_coef_pkg::TAP1_OFF;
    rel[2] = addr_in - fir_coef_pkg::TAP2_OFF;
    rel[3] = addr_in - fir_coef_pkg::TAP3_OFF;
    rel[4] = addr_in - fir_coef_pkg::TAP4C_OFF;
    rel[5] = addr_in - fir_coef_pkg::TAP5_OFF;
    hit[0] = (addr_in >= fir_coef_pkg::TAP0_OFF) && (rel[0] < 12'(SIDE_NB));
    hit[1] = (addr_in >= fir_coef_pkg::TAP1_OFF) && (rel[1] < 12'(SIDE_NB));
    hit[2] = (addr_in >= fir_coef_pkg::TAP2_OFF) && (rel[2] < 12'(SIDE_NB));
    hit[3] = (addr_in >= fir_coef_pkg::TAP3_OFF) && (rel[3] < 12'(SIDE_NB));
    hit[4] = (addr_in >= fir_coef_pkg::TAP4C_OFF) && (rel[4] < 12'(CTR_NB));
    hit[5] = (addr_in >= fir_coef_pkg::TAP5_OFF) && (rel[5] < 12'(SIDE_NB));
    bsel[0] = rel[0][1:0];
    bsel[1] = rel[1][1:0];
    bsel[2] = rel[2][1:0];
    bsel[3] = rel[3][1:0];
    bsel[4] = rel[4][1:0];
    bsel[5] = rel[5][1:0];
  end

  coef_byte_reg #(
    .NBYTES(SIDE_NB)
  ) tap0_u (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .wr_in      (wr_ok && hit[0]),
    .byte_sel_in(bsel[0]),
    .wdata_in   (wdata_in),
    .value_out  (tap0_value)
  );

  coef_byte_reg #(
    .NBYTES(SIDE_NB)
  ) tap1_u (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .wr_in      (wr_ok && hit[1]),
    .byte_sel_in(bsel[1]),
    .wdata_in   (wdata_in),
    .value_out  (tap1_value)
  );

  coef_byte_reg #(
    .NBYTES(SIDE_NB)
  ) tap2_u (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .wr_in      (wr_ok && hit[2]),
    .byte_sel_in(bsel[2]),
    .wdata_in   (wdata_in),
    .value_out  (tap2_value)
  );

  coef_byte_reg #(
    .NBYTES(SIDE_NB)
  ) tap3_u (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .wr_in      (wr_ok && hit[3]),
    .byte_sel_in(bsel[3]),
    .wdata_in   (wdata_in),
    .value_out  (tap3_value)
  );

  // Center tap is the only three-byte register
  coef_byte_reg #(
    .NBYTES(CTR_NB)
  ) tap4_u (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .wr_in      (wr_ok && hit[4]),
    .byte_sel_in(bsel[4]),
    .wdata_in   (wdata_in),
    .value_out  (tap4_value)
  );

  coef_byte_reg #(
    .NBYTES(SIDE_NB)
  ) tap5_u (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .wr_in      (wr_ok && hit[5]),
    .byte_sel_in(bsel[5]),
    .wdata_in   (wdata_in),
    .value_out  (tap5_value)
  );

  assign val[0] = 24'(tap0_value);
  assign val[1] = 24'(tap1_value);
  assign val[2] = 24'(tap2_value);
  assign val[3] = 24'(tap3_value);
  assign val[4] = tap4_value;
  assign val[5] = 24'(tap5_value);

  // Byte read mux; unmapped addresses read as zero
  always_comb
  begin
    rd_byte = 8'h00;
    case (addr_in)
      fir_coef_pkg::CFG_OFF:             rd_byte = s_q.cfg;
      fir_coef_pkg::TAP0_OFF:            rd_byte = tap0_value[7:0];
      fir_coef_pkg::TAP0_OFF + 12'h001:  rd_byte = tap0_value[15:8];
      fir_coef_pkg::TAP1_OFF:            rd_byte = tap1_value[7:0];
      fir_coef_pkg::TAP1_OFF + 12'h001:  rd_byte = tap1_value[15:8];
      fir_coef_pkg::TAP2_OFF:            rd_byte = tap2_value[7:0];
      fir_coef_pkg::TAP2_OFF + 12'h001:  rd_byte = tap2_value[15:8];
      fir_coef_pkg::TAP3_OFF:            rd_byte = tap3_value[7:0];
      fir_coef_pkg::TAP3_OFF + 12'h001:  rd_byte = tap3_value[15:8];
      fir_coef_pkg::TAP4C_OFF:           rd_byte = tap4_value[7:0];
      fir_coef_pkg::TAP4C_OFF + 12'h001: rd_byte = tap4_value[15:8];
      fir_coef_pkg::TAP4C_OFF + 12'h002: rd_byte = tap4_value[23:16];
      fir_coef_pkg::TAP5_OFF:            rd_byte = tap5_value[7:0];
      fir_coef_pkg::TAP5_OFF + 12'h001:  rd_byte = tap5_value[15:8];
      default:                           rd_byte = 8'h00;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    s_d.ignored = wr_in && serial_link_enable_in;
    if (wr_ok && addr_in == fir_coef_pkg::CFG_OFF)
      s_d.cfg = wdata_in;
    if (rd_in)
      s_d.rdata = rd_byte;
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      s_q <= '{cfg: fir_coef_pkg::CFG_RESET, rdata: 8'h00, ignored: 1'b0};
    else
      s_q <= s_d;
  end

  logic [2:0] scw;
  assign scw = s_q.cfg[fir_coef_pkg::SCW_LSB +: 3];

  assign rdata_out               = s_q.rdata;
  assign config_write_ignored_out = s_q.ignored;
  assign filter_mode_out         = s_q.cfg[fir_coef_pkg::MODE_LSB +: 2];
  // Reserved modes leave the filter bypassed
  assign filter_active_out =
    (filter_mode_out == fir_coef_pkg::MODE_ACTIVE);
  assign filter_merge_out        = s_q.cfg[fir_coef_pkg::MERGE_BIT];
  assign coefficient_sharing_out = s_q.cfg[fir_coef_pkg::SHARE_BIT];
  assign taps_a_drive_b_out      = coefficient_sharing_out;
  assign side_coefficient_weight_out = scw;
  // LSB weight is 2^(scw-16); settings above 6 clamp to 6
  assign side_lsb_exponent_out = 5'h10 -
    5'((scw > fir_coef_pkg::SCW_MAX) ? fir_coef_pkg::SCW_MAX : scw);

  // Only tap0..tap5 exist here; taps seven to nine are zero
  always_comb
  begin
    side_taps_a_out = '0;
    side_taps_a_out[0*12 +: 12] = val[0][11:0];
    side_taps_a_out[1*12 +: 12] = val[1][11:0];
    side_taps_a_out[2*12 +: 12] = val[2][11:0];
    side_taps_a_out[3*12 +: 12] = val[3][11:0];
    side_taps_a_out[4*12 +: 12] = val[5][11:0];
  end
  assign center_tap_a_out = val[fir_coef_pkg::CENTER_IDX][17:0];
endmodule

// ===== test/fir_bank_chk.sv
// Port checker for the channel A coefficient store.
// Assumes it is bound onto fir_coefficient_bank_a.
`timescale 1ns/1ps
module fir_bank_chk (
  input wire logic        clock_in,
  input wire logic        rst_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic        serial_link_enable_in,
  input wire logic [7:0]  rdata_out,
  input wire logic [1:0]  filter_mode_out,
  input wire logic        filter_active_out,
  input wire logic        coefficient_sharing_out,
  input wire logic [2:0]  side_coefficient_weight_out,
  input wire logic [4:0]  side_lsb_exponent_out,
  input wire logic [95:0] side_taps_a_out,
  input wire logic [17:0] center_tap_a_out,
  input wire logic        taps_a_drive_b_out,
  input wire logic        config_write_ignored_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence blocked_wr_s;
    wr_in && serial_link_enable_in;
  endsequence
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside answer cycle");
  mode_active_a: assert property
    (filter_active_out == (filter_mode_out == 2'h2)) else $error("active");
  share_drive_a: assert property
    (taps_a_drive_b_out == coefficient_sharing_out) else $error("share");
  weight_exp_a: assert property (side_coefficient_weight_out <= 3'h6 |->
    side_lsb_exponent_out == 5'h10 - side_coefficient_weight_out)
    else $error("side exponent");
  refuse_pulse_a: assert property (blocked_wr_s |=> config_write_ignored_out)
    else $error("no refusal pulse");
  pulse_cause_a: assert property
    (config_write_ignored_out |-> $past(wr_in && serial_link_enable_in))
    else $error("stray refusal pulse");
  link_hold_a: assert property (serial_link_enable_in |=>
    $stable(center_tap_a_out) && $stable(side_taps_a_out)) else $error("hold");
  unused_slot_a: assert property
    (side_taps_a_out[95:60] == 36'h0_0000_0000) else $error("slots 5-7");
  reset_zero_a: assert property
    ($past(rst_in) |-> center_tap_a_out == 18'h0_0000) else $error("reset");
endmodule
bind fir_coefficient_bank_a fir_bank_chk chk_u (.*);

// ===== test/testbench.sv
// Self-checking bench for the channel A coefficient store.
// Assumes a 100 MHz clock and the one-cycle register port.
`timescale 1ns/1ps
module testbench;
  logic        clock_in = 0, rst_in = 1, wr_in = 0, rd_in = 0;
  logic        serial_link_enable_in = 0;
  logic [11:0] addr_in = 12'h0000;
  logic [7:0]  wdata_in = 8'h00, rdata_out;
  logic [7:0]  m [13];
  logic [1:0]  filter_mode_out;
  logic        filter_active_out, filter_merge_out, coefficient_sharing_out;
  logic        taps_a_drive_b_out, config_write_ignored_out;
  logic [2:0]  side_coefficient_weight_out;
  logic [4:0]  side_lsb_exponent_out;
  logic [95:0] side_taps_a_out;
  logic [17:0] center_tap_a_out;
  int          err_total = 0, comparisons = 0;
  fir_coefficient_bank_a dut_u (
    .clock_in                   (clock_in),
    .rst_in                     (rst_in),
    .addr_in                    (addr_in),
    .wdata_in                   (wdata_in),
    .wr_in                      (wr_in),
    .rd_in                      (rd_in),
    .serial_link_enable_in      (serial_link_enable_in),
    .rdata_out                  (rdata_out),
    .filter_mode_out            (filter_mode_out),
    .filter_active_out          (filter_active_out),
    .filter_merge_out           (filter_merge_out),
    .coefficient_sharing_out    (coefficient_sharing_out),
    .side_coefficient_weight_out(side_coefficient_weight_out),
    .side_lsb_exponent_out      (side_lsb_exponent_out),
    .side_taps_a_out            (side_taps_a_out),
    .center_tap_a_out           (center_tap_a_out),
    .taps_a_drive_b_out         (taps_a_drive_b_out),
    .config_write_ignored_out   (config_write_ignored_out)
  );
  always #5 clock_in = ~clock_in;
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  // Bytes 0x418..0x424 cover tap0 to tap5 including the center tap
  task automatic regs_test;
    for (int k = 0; k < 13; k++)
    begin
      m[k] = 8'(8'h21 + 8'h13 * k);
      rd(12'h0418 + 12'(k), 8'h00);
      wr(12'h0418 + 12'(k), m[k]);
      rd(12'h0418 + 12'(k), m[k]);
    end
    for (int j = 0; j < 4; j++)
      chk(side_taps_a_out[j*12+:12], {m[2*j+1][3:0], m[2*j]});
    chk(side_taps_a_out[48+:12], {m[12][3:0], m[11]});
    chk(center_tap_a_out, {m[10][1:0], m[9], m[8]});
  endtask
  task automatic link_test;
    @(posedge clock_in) serial_link_enable_in <= 1'b1;
    wr(12'h0420, 8'hff);
    #1 chk(config_write_ignored_out, 1'b1);
    chk(center_tap_a_out, {m[10][1:0], m[9], m[8]});
    wr(12'h0400, 8'h02);
    #1 chk(config_write_ignored_out, 1'b1);
    chk(filter_active_out, 1'b0);
    @(posedge clock_in) serial_link_enable_in <= 1'b0;
  endtask
  task automatic cfg_test;
    wr(12'h0400, 8'h5a);
    #1 chk(filter_active_out, 1'b1);
    chk(filter_mode_out, 2'h2);
    chk(side_lsb_exponent_out, 5'h0a);
    chk(side_coefficient_weight_out, 3'h6);
    chk(taps_a_drive_b_out, 1'b1);
    chk(coefficient_sharing_out, 1'b1);
    chk(filter_merge_out, 1'b0);
    chk(config_write_ignored_out, 1'b0);
    rd(12'h0400, 8'h5a);
    wr(12'h0400, 8'hbd);
    #1 chk(filter_active_out, 1'b0);
    chk(filter_mode_out, 2'h1);
    chk(side_lsb_exponent_out, 5'h0a);
    chk(filter_merge_out, 1'b1);
    chk(taps_a_drive_b_out, 1'b0);
    rd(12'h0400, 8'hbd);
    wr(12'h0400, 8'h63);
    #1 chk(filter_active_out, 1'b0);
    chk(side_lsb_exponent_out, 5'h10);
    chk(taps_a_drive_b_out, 1'b1);
    rd(12'h0400, 8'h63);
    rd(12'h0500, 8'h00);
  endtask
  // Mid-run reset after every register holds a nonzero value
  task automatic reset_test;
    @(posedge clock_in) rst_in <= 1'b1;
    @(posedge clock_in) rst_in <= 1'b0;
    #1 chk(center_tap_a_out, 18'h0_0000);
    chk(|side_taps_a_out, 1'b0);
    chk(side_lsb_exponent_out, 5'h10);
    chk(filter_mode_out, 2'h0);
    chk(filter_active_out, 1'b0);
    rd(12'h0400, 8'h00);
    rd(12'h0422, 8'h00);
  endtask
  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    regs_test;
    link_test;
    cfg_test;
    reset_test;
    tally_and_finish;
  end
  // Tests take under 300 cycles; 20000 cycles means a hang
  initial
  begin
    #200000;
    err_total++;
    tally_and_finish;
  end
endmodule
